// ### srdl_buf2.sv
// Purpose: two-entry valid/ready buffer in the read data path
// Assumes: single clock, source and sink on clk_sys
// Notes:   out_data comes straight from the head flop
`timescale 1ns/100ps
`default_nettype none
module srdl_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic [1:0]        cnt;
  } srdl_b2_t;

  srdl_b2_t q;
  srdl_b2_t n;
  logic     push;
  logic     pop;

  always_comb begin
    n         = q;
    in_ready  = (q.cnt != 2'h2);
    out_valid = (q.cnt != 2'h0);
    out_data  = q.mem[0];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    if (pop) begin
      n.mem[0] = q.mem[1];
    end
    if (push) begin
      if (q.cnt == 2'h0 || (q.cnt == 2'h1 && pop)) begin
        n.mem[0] = in_data;
      end else begin
        n.mem[1] = in_data;
      end
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : srdl_buf2
`default_nettype wire

// ### srdl_host_model.sv
// Purpose: host side model making the command clock and command pins
// Assumes: command clock runs free with a 160 ns period
// Notes:   a command is set up on a falling edge, taken on the next rise
`timescale 1ns/100ps
`default_nettype none
module srdl_host_model (
  output var logic               ck4_pin,
  output var srdl_pkg::srdl_ca_t ca_pin
);
  realtime     cmd_t;
  logic [15:0] open_q;

  initial begin
    ck4_pin = 1'b0;
    ca_pin  = '0;
    open_q  = '0;
    cmd_t   = 0.0;
    #3;
    forever #80 ck4_pin = ~ck4_pin;
  end

  // one command per call, even parity unless bad is set
  task automatic send(input srdl_pkg::srdl_cmd_t c, input logic [3:0] b,
                      input logic bad);
    @(negedge ck4_pin);
    ca_pin <= '{cmd: c, bank: b, parity: (^{c, b}) ^ bad};
    @(posedge ck4_pin);
    cmd_t = $realtime;
    if (c == srdl_pkg::CMD_ROW_OPEN) open_q[b] = 1'b1;
    if (c == srdl_pkg::CMD_CLOSE) open_q[b] = 1'b0;
    @(negedge ck4_pin);
    ca_pin <= '0;
  endtask : send
endmodule : srdl_host_model
`default_nettype wire

// ### srdl_pkg.sv
// Purpose: shared constants and types for the read data lane block
// Assumes: 100 MHz clk_sys, lane levels coded as two-bit symbols
// Notes:   offsets are word indexes on the plain register port
package srdl_pkg;
  localparam int          DQ_W       = 10;
  localparam int          NRZ_LANES  = 8;
  localparam int          LAUNCH_W   = 64;
  localparam int          DLY_W      = 16;
  localparam int          GRADE_SYMS = 4;
  localparam logic [1:0]  LVL_ZERO   = 2'h0;
  localparam logic [1:0]  LVL_PLUS   = 2'h1;
  localparam logic [1:0]  LVL_MINUS  = 2'h3;
  localparam logic [5:0]  LAST_PAM3  = 6'h0f;
  localparam logic [5:0]  LAST_NRZ   = 6'h1f;
  localparam logic [3:0]  ADDR_CFG   = 4'h0;
  localparam logic [3:0]  ADDR_LAT   = 4'h1;
  localparam logic [3:0]  ADDR_OFS   = 4'h2;
  localparam logic [3:0]  ADDR_STAT  = 4'h3;
  localparam int          LAT_RL_LSB  = 0;
  localparam int          LAT_P2F_LSB = 8;
  localparam int          OFS_DQO_LSB = 0;
  localparam int          OFS_ERR_LSB = 8;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_UNDER   = 1;
  localparam int          ST_PARERR  = 2;
  localparam int          ST_CLOSED  = 3;
  localparam logic [7:0]  CFG_RST    = 8'h40;
  localparam logic [5:0]  RL_RST     = 6'h05;
  localparam logic [5:0]  P2F_RST    = 6'h02;
  localparam logic [3:0]  DQO_RST    = 4'h0;
  localparam logic [3:0]  ERRO_RST   = 4'h0;

  typedef enum logic [1:0] {
    CMD_NONE     = 2'b00,
    CMD_ROW_OPEN = 2'b01,
    CMD_READ     = 2'b10,
    CMD_CLOSE    = 2'b11
  } srdl_cmd_t;

  typedef enum logic {
    BST_IDLE = 1'b0,
    BST_RUN  = 1'b1
  } srdl_burst_t;

  typedef struct packed {
    srdl_cmd_t  cmd;
    logic [3:0] bank;
    logic       parity;
  } srdl_ca_t;

  typedef struct packed {
    logic [DQ_W-1:0][1:0] dq;
    logic [1:0]           edl;
  } srdl_word_t;

  typedef struct packed {
    logic parity_en;
    logic term_en;
    logic lane_float_enable;
    logic write_check_enable;
    logic poison_en;
    logic grade_en;
    logic read_check_enable;
    logic pam3;
  } srdl_cfg_t;

  typedef struct packed {
    logic [DQ_W-1:0][1:0] dq_lvl;
    logic [DQ_W-1:0]      dq_oe;
    logic [1:0]           error_detect_lane;
    logic                 edl_oe;
    logic [1:0]           flag_lvl;
    logic                 flag_oe;
  } srdl_pins_t;
endpackage : srdl_pkg

// ### srdl_top.sv
// Purpose: device-side read burst, error-detect lane and parity flag
// Assumes: command clock and command pins are asynchronous to clk_sys
// Notes:   one burst element per command clock rising edge
// Function
// RULE1 - nrz poison only: data in reads, else termination
// RULE2 - nrz write check only: lane never driven low
// RULE3 - over two checks enabled: lane carries payloads
// RULE4 - first element after latency count plus offset
// RULE5 - host trains to find clock-to-output offset
// RULE6 - host opens row and waits before read
// RULE7 - parity only: flag plus one, minus on error
// RULE8 - parity flag after count plus output offset
// RULE9 - host spaces fast reads to different banks
// RULE10 - pam3 no read check: grade, poison, then plus
// RULE11 - bursts 16 or 32 long, never truncated
// RULE12 - after burst drive plus/high or float
// RULE13 - host captures only inside burst windows
`timescale 1ns/100ps
`default_nettype none
module srdl_top (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                ck4_pin,
  input  wire srdl_pkg::srdl_ca_t  ca_pin,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                src_valid,
  input  wire srdl_pkg::srdl_word_t src_word,
  output logic                     src_ready,
  output srdl_pkg::srdl_pins_t     pins
);
  typedef struct packed {
    logic                        ck_s1;
    logic                        ck_s2;
    logic                        ck_s3;
    srdl_pkg::srdl_ca_t          ca_s1;
    srdl_pkg::srdl_ca_t          ca_s2;
    srdl_pkg::srdl_cfg_t         cfg;
    logic [5:0]                  read_latency_count;
    logic [5:0]                  parity_to_flag_count;
    logic [3:0]                  clock_to_output_offset;
    logic [3:0]                  flag_output_offset;
    logic                        under;
    logic                        parerr;
    logic                        closed;
    logic [15:0]                 open;
    logic [srdl_pkg::LAUNCH_W-1:0] launch;
    logic [srdl_pkg::LAUNCH_W-1:0] pflag;
    logic [srdl_pkg::DLY_W-1:0]  ldly;
    logic [srdl_pkg::DLY_W-1:0]  fdly;
    logic [5:0]                  pend;
    srdl_pkg::srdl_burst_t       st;
    logic [5:0]                  idx;
    srdl_pkg::srdl_word_t        cur;
    logic                        flag_low;
    srdl_pkg::srdl_pins_t        pins;
    logic [31:0]                 rdata;
  } srdl_state_t;

  srdl_state_t          q;
  srdl_state_t          n;
  logic                 edge_q;
  logic                 launch_hit;
  logic                 tap;
  logic                 flag_hit;
  logic                 ftap;
  logic                 pop;
  logic                 buf_valid;
  srdl_pkg::srdl_word_t buf_word;
  logic [2:0]           chk_cnt;
  logic                 nrz_data;
  logic [5:0]           last;

  srdl_buf2 #(
    .W ($bits(srdl_pkg::srdl_word_t))
  ) u_buf (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (src_valid),
    .in_data   (src_word),
    .in_ready  (src_ready),
    .out_valid (buf_valid),
    .out_data  (buf_word),
    .out_ready (pop)
  );

  assign reg_rdata = q.rdata;
  assign pins      = q.pins;
  assign edge_q    = q.ck_s2 & ~q.ck_s3;
  assign launch_hit = edge_q & q.launch[0];
  assign flag_hit  = edge_q & q.pflag[0];
  assign tap  = (q.clock_to_output_offset == 4'h0) ? launch_hit
              : q.ldly[q.clock_to_output_offset - 4'h1];
  assign ftap = (q.flag_output_offset == 4'h0) ? flag_hit
              : q.fdly[q.flag_output_offset - 4'h1];
  assign chk_cnt = {2'b0, q.cfg.read_check_enable} + {2'b0, q.cfg.grade_en}
                 + {2'b0, q.cfg.poison_en}
                 + {2'b0, q.cfg.write_check_enable};
  assign last = q.cfg.pam3 ? srdl_pkg::LAST_PAM3 : srdl_pkg::LAST_NRZ;

  always_comb begin
    n        = q;
    pop      = 1'b0;
    nrz_data = 1'b0;
    n.ck_s1  = ck4_pin;
    n.ck_s2  = q.ck_s1;
    n.ck_s3  = q.ck_s2;
    n.ca_s1  = ca_pin;
    n.ca_s2  = q.ca_s1;
    n.rdata  = 32'h0;
    // register port
    if (reg_wr) begin
      if (reg_addr == srdl_pkg::ADDR_CFG) begin
        n.cfg = reg_wdata[7:0];
      end else if (reg_addr == srdl_pkg::ADDR_LAT) begin
        n.read_latency_count =
          reg_wdata[srdl_pkg::LAT_RL_LSB +: 6];
        n.parity_to_flag_count =
          reg_wdata[srdl_pkg::LAT_P2F_LSB +: 6];
      end else if (reg_addr == srdl_pkg::ADDR_OFS) begin
        n.clock_to_output_offset =
          reg_wdata[srdl_pkg::OFS_DQO_LSB +: 4];
        n.flag_output_offset = reg_wdata[srdl_pkg::OFS_ERR_LSB +: 4];
      end else if (reg_addr == srdl_pkg::ADDR_STAT) begin
        n.under  = q.under & ~reg_wdata[srdl_pkg::ST_UNDER];
        n.parerr = q.parerr & ~reg_wdata[srdl_pkg::ST_PARERR];
        n.closed = q.closed & ~reg_wdata[srdl_pkg::ST_CLOSED];
      end
    end
    if (reg_rd) begin
      if (reg_addr == srdl_pkg::ADDR_CFG) begin
        n.rdata[7:0] = q.cfg;
      end else if (reg_addr == srdl_pkg::ADDR_LAT) begin
        n.rdata[srdl_pkg::LAT_RL_LSB +: 6]  = q.read_latency_count;
        n.rdata[srdl_pkg::LAT_P2F_LSB +: 6] = q.parity_to_flag_count;
      end else if (reg_addr == srdl_pkg::ADDR_OFS) begin
        n.rdata[srdl_pkg::OFS_DQO_LSB +: 4] = q.clock_to_output_offset;
        n.rdata[srdl_pkg::OFS_ERR_LSB +: 4] = q.flag_output_offset;
      end else if (reg_addr == srdl_pkg::ADDR_STAT) begin
        n.rdata[srdl_pkg::ST_BUSY]   = (q.st == srdl_pkg::BST_RUN);
        n.rdata[srdl_pkg::ST_UNDER]  = q.under;
        n.rdata[srdl_pkg::ST_PARERR] = q.parerr;
        n.rdata[srdl_pkg::ST_CLOSED] = q.closed;
      end
    end
    // command decode on each command clock rising edge
    if (edge_q) begin
      n.launch = q.launch >> 1;
      n.pflag  = q.pflag >> 1;
      if (q.ca_s2.cmd == srdl_pkg::CMD_ROW_OPEN) begin
        n.open[q.ca_s2.bank] = 1'b1;
      end else if (q.ca_s2.cmd == srdl_pkg::CMD_CLOSE) begin
        n.open[q.ca_s2.bank] = 1'b0;
      end else if (q.ca_s2.cmd == srdl_pkg::CMD_READ) begin
        if (!q.open[q.ca_s2.bank]) begin
          n.closed = 1'b1; // [RULE6]
        end
        // [RULE4]
        n.launch[(q.read_latency_count == 6'h0) ? 6'h0
                 : q.read_latency_count - 6'h1] = 1'b1;
      end
      if (q.cfg.parity_en && q.ca_s2.cmd != srdl_pkg::CMD_NONE
          && ((^{q.ca_s2.cmd, q.ca_s2.bank}) != q.ca_s2.parity)) begin
        n.parerr = 1'b1;
        // [RULE8]
        n.pflag[(q.parity_to_flag_count == 6'h0) ? 6'h0
                : q.parity_to_flag_count - 6'h1] = 1'b1;
      end
    end
    n.ldly = {q.ldly[srdl_pkg::DLY_W-2:0], launch_hit}; // [RULE4]
    n.fdly = {q.fdly[srdl_pkg::DLY_W-2:0], flag_hit}; // [RULE8]
    if (edge_q) begin
      n.flag_low = 1'b0;
    end
    if (ftap) begin
      n.flag_low = 1'b1; // [RULE8]
    end
    // burst engine, queued bursts concatenate
    n.pend = q.pend + {5'h0, tap};
    case (q.st)
      srdl_pkg::BST_IDLE: begin
        if (n.pend != 6'h0) begin
          n.pend = n.pend - 6'h1;
          n.st   = srdl_pkg::BST_RUN;
          n.idx  = 6'h0;
          pop    = 1'b1;
        end
      end
      srdl_pkg::BST_RUN: begin
        if (edge_q) begin
          if (q.idx != last) begin
            n.idx = q.idx + 6'h1; // [RULE11]
            pop   = 1'b1;
          end else if (n.pend != 6'h0) begin
            n.pend = n.pend - 6'h1;
            n.idx  = 6'h0;
            pop    = 1'b1;
          end else begin
            n.st = srdl_pkg::BST_IDLE;
          end
        end
      end
      default: n.st = srdl_pkg::BST_IDLE;
    endcase
    if (pop) begin
      if (buf_valid) begin
        n.cur = buf_word;
      end else begin
        n.under        = 1'b1;
        n.cur.dq       = {srdl_pkg::DQ_W{srdl_pkg::LVL_PLUS}};
        n.cur.edl      = srdl_pkg::LVL_PLUS;
      end
    end
    // dq lanes
    for (int i = 0; i < srdl_pkg::DQ_W; i++) begin
      if (n.st == srdl_pkg::BST_RUN) begin
        n.pins.dq_oe[i]  = n.cfg.pam3 || (i < srdl_pkg::NRZ_LANES);
        n.pins.dq_lvl[i] = (!n.cfg.pam3
                            && n.cur.dq[i] != srdl_pkg::LVL_MINUS)
                           ? srdl_pkg::LVL_PLUS : n.cur.dq[i];
      end else begin
        n.pins.dq_oe[i]  = n.cfg.term_en
                           && (n.cfg.pam3 || i < srdl_pkg::NRZ_LANES);
        n.pins.dq_lvl[i] = srdl_pkg::LVL_PLUS; // [RULE12]
      end
    end
    // error-detect lane
    nrz_data = n.cfg.read_check_enable | n.cfg.grade_en
               | n.cfg.poison_en | (chk_cnt > 3'h2); // [RULE3]
    if (!n.cfg.pam3 && n.cfg.lane_float_enable) begin
      n.pins.edl_oe            = 1'b0;
      n.pins.error_detect_lane = srdl_pkg::LVL_ZERO;
    end else if (n.st == srdl_pkg::BST_RUN
                 && (n.cfg.pam3 || nrz_data)) begin
      n.pins.edl_oe = 1'b1; // [RULE1] [RULE3]
      if (n.cfg.pam3 && !n.cfg.read_check_enable
          && n.idx >= 6'(srdl_pkg::GRADE_SYMS)) begin
        n.pins.error_detect_lane = srdl_pkg::LVL_PLUS; // [RULE10]
      end else if (!n.cfg.pam3
                   && n.cur.edl != srdl_pkg::LVL_MINUS) begin
        n.pins.error_detect_lane = srdl_pkg::LVL_PLUS;
      end else begin
        n.pins.error_detect_lane = n.cur.edl;
      end
    end else if (!n.cfg.pam3 && !nrz_data) begin
      n.pins.edl_oe            = 1'b1; // [RULE2]
      n.pins.error_detect_lane = srdl_pkg::LVL_PLUS;
    end else begin
      n.pins.edl_oe            = n.cfg.term_en; // [RULE1] [RULE12]
      n.pins.error_detect_lane = srdl_pkg::LVL_PLUS;
    end
    // fault indicator pin
    n.pins.flag_oe  = 1'b1;
    n.pins.flag_lvl = (n.cfg.parity_en && n.flag_low)
                      ? srdl_pkg::LVL_MINUS : srdl_pkg::LVL_PLUS; // [RULE7]
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q                        <= '0;
      q.cfg                    <= srdl_pkg::CFG_RST;
      q.read_latency_count     <= srdl_pkg::RL_RST;
      q.parity_to_flag_count   <= srdl_pkg::P2F_RST;
      q.clock_to_output_offset <= srdl_pkg::DQO_RST;
      q.flag_output_offset     <= srdl_pkg::ERRO_RST;
      q.pins.dq_lvl            <= {srdl_pkg::DQ_W{srdl_pkg::LVL_PLUS}};
      q.pins.flag_oe           <= 1'b1;
      q.pins.flag_lvl          <= srdl_pkg::LVL_PLUS;
    end else begin
      q <= n;
    end
  end

  property p_rule1;
    @(posedge clk_sys) disable iff (!nrst)
      (!q.cfg.pam3 && q.cfg.poison_en && !q.cfg.read_check_enable
       && !q.cfg.grade_en && !q.cfg.write_check_enable
       && !q.cfg.lane_float_enable)
      |-> q.pins.edl_oe == ((q.st == srdl_pkg::BST_RUN) || q.cfg.term_en);
  endproperty
  a_rule1: assert property (p_rule1) // [RULE1]
    else $error("poison-only lane state wrong");

  property p_rule2;
    @(posedge clk_sys) disable iff (!nrst)
      (!q.cfg.pam3 && q.cfg.write_check_enable && chk_cnt == 3'h1
       && !q.cfg.lane_float_enable)
      |-> q.pins.edl_oe
          && q.pins.error_detect_lane != srdl_pkg::LVL_MINUS;
  endproperty
  a_rule2: assert property (p_rule2) // [RULE2]
    else $error("write-check-only lane driven low or floated");

  property p_rule3;
    @(posedge clk_sys) disable iff (!nrst)
      (!q.cfg.pam3 && chk_cnt > 3'h2 && !q.cfg.lane_float_enable
       && q.st == srdl_pkg::BST_RUN && q.cur.edl == srdl_pkg::LVL_MINUS)
      |-> q.pins.edl_oe
          && q.pins.error_detect_lane == srdl_pkg::LVL_MINUS;
  endproperty
  a_rule3: assert property (p_rule3) // [RULE3]
    else $error("payload missing on lane");

  property p_rule4_place;
    @(posedge clk_sys) disable iff (!nrst)
      (edge_q && q.ca_s2.cmd == srdl_pkg::CMD_READ
       && q.read_latency_count == 6'h1) |=> q.launch[0];
  endproperty
  a_rule4_place: assert property (p_rule4_place) // [RULE4]
    else $error("latency slot not set");

  property p_rule4_start;
    @(posedge clk_sys) disable iff (!nrst)
      (launch_hit && q.clock_to_output_offset == 4'h2
       && q.st == srdl_pkg::BST_IDLE && q.pend == 6'h0)
      |-> ##1 q.st == srdl_pkg::BST_IDLE ##2 q.st == srdl_pkg::BST_RUN;
  endproperty
  a_rule4_start: assert property (p_rule4_start) // [RULE4]
    else $error("burst start not at offset");

  property p_rule7;
    @(posedge clk_sys) disable iff (!nrst)
      q.cfg.parity_en |-> q.pins.flag_oe
        && (q.pins.flag_lvl == srdl_pkg::LVL_PLUS
            || q.pins.flag_lvl == srdl_pkg::LVL_MINUS);
  endproperty
  a_rule7: assert property (p_rule7) // [RULE7]
    else $error("flag pin level invalid");

  property p_rule8;
    @(posedge clk_sys) disable iff (!nrst)
      (ftap && q.cfg.parity_en && !reg_wr)
      |=> q.pins.flag_lvl == srdl_pkg::LVL_MINUS && q.parerr;
  endproperty
  a_rule8: assert property (p_rule8) // [RULE8]
    else $error("parity flag not raised");

  property p_rule10;
    @(posedge clk_sys) disable iff (!nrst)
      (q.cfg.pam3 && !q.cfg.read_check_enable
       && q.st == srdl_pkg::BST_RUN
       && q.idx >= 6'(srdl_pkg::GRADE_SYMS))
      |-> q.pins.edl_oe
          && q.pins.error_detect_lane == srdl_pkg::LVL_PLUS;
  endproperty
  a_rule10: assert property (p_rule10) // [RULE10]
    else $error("trailing symbols not plus one");

  property p_rule11;
    @(posedge clk_sys) disable iff (!nrst)
      (q.st == srdl_pkg::BST_RUN && !(edge_q && q.idx == last))
      |=> q.st == srdl_pkg::BST_RUN;
  endproperty
  a_rule11: assert property (p_rule11) // [RULE11]
    else $error("burst truncated");

  property p_rule12;
    @(posedge clk_sys) disable iff (!nrst)
      (q.st == srdl_pkg::BST_IDLE && !$changed(q.cfg) && $past(nrst))
      |-> q.pins.dq_lvl == {srdl_pkg::DQ_W{srdl_pkg::LVL_PLUS}}
          && q.pins.dq_oe[0] == q.cfg.term_en;
  endproperty
  a_rule12: assert property (p_rule12) // [RULE12]
    else $error("idle dq lanes wrong");
endmodule : srdl_top
`default_nettype wire

// ### test_srdl_top.sv
// Purpose: self-checking bench for the read data lane block
// Assumes: host model makes the command clock, bench feeds burst words
// Notes:   latencies compared as differences, clock phase is fixed
`timescale 1ns/100ps
`default_nettype none
module test_srdl_top;
  logic                 clk_sys;
  logic                 nrst;
  logic                 ck4_pin;
  srdl_pkg::srdl_ca_t   ca_pin;
  logic [3:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic                 src_valid;
  srdl_pkg::srdl_word_t src_word;
  logic                 src_ready;
  srdl_pkg::srdl_pins_t pins;
  logic                 feed_on;
  int                   bad_count;
  int                   tests_run;
  int                   lat0;
  int                   lat;

  srdl_host_model i_srdl_host_model (
    .ck4_pin (ck4_pin),
    .ca_pin  (ca_pin)
  );

  srdl_top i_srdl_top (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ck4_pin   (ck4_pin),
    .ca_pin    (ca_pin),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .src_valid (src_valid),
    .src_word  (src_word),
    .src_ready (src_ready),
    .pins      (pins)
  );

  always #5 clk_sys = ~clk_sys;

  // feeder keeps the buffer topped up, holds valid until taken
  always @(posedge clk_sys) begin
    src_valid <= feed_on | (src_valid & ~src_ready);
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : reg_check

  // read bank 1, time the first element, walk all elements and the idle
  task automatic read_scan(input int n, input int n_src, output int l);
    int         k;
    logic [1:0] e_dq;
    logic [1:0] e_edl;
    i_srdl_host_model.send(srdl_pkg::CMD_READ, 4'h1, 1'b0);
    k = 0;
    while (pins.dq_lvl[0] !== srdl_pkg::LVL_MINUS && k < 400) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    l = int'(($realtime - i_srdl_host_model.cmd_t) / 10.0);
    chk("first_elem", srdl_pkg::LVL_MINUS, pins.dq_lvl[0]);
    chk("dq9_oe", (n == 16), pins.dq_oe[9]);
    repeat (8) @(posedge clk_sys);
    for (k = 0; k <= n; k++) begin
      #1;
      e_dq  = (k < n) ? srdl_pkg::LVL_MINUS : srdl_pkg::LVL_PLUS;
      e_edl = (k < n_src) ? srdl_pkg::LVL_MINUS : srdl_pkg::LVL_PLUS;
      chk("dq_lane", e_dq, pins.dq_lvl[0]);
      chk("edl_lane", e_edl, pins.error_detect_lane);
      chk("edl_oe", 32'h1, pins.edl_oe);
      repeat (16) @(posedge clk_sys);
    end
  endtask : read_scan

  // command with bad parity, time the flag going low
  task automatic par_lat(output int l);
    int k;
    i_srdl_host_model.send(srdl_pkg::CMD_CLOSE, 4'h2, 1'b1);
    k = 0;
    while (pins.flag_lvl !== srdl_pkg::LVL_MINUS && k < 400) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    l = int'(($realtime - i_srdl_host_model.cmd_t) / 10.0);
    chk("flag_err", srdl_pkg::LVL_MINUS, pins.flag_lvl);
    repeat (40) @(posedge clk_sys);
  endtask : par_lat

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    clk_sys   = 1'b0;
    nrst      = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    src_valid = 1'b0;
    src_word  = {11{srdl_pkg::LVL_MINUS}};
    feed_on   = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("edl_idle", srdl_pkg::LVL_PLUS, pins.error_detect_lane);
    chk("flag_oe", 32'h1, pins.flag_oe);
    reg_check(srdl_pkg::ADDR_CFG, 32'h40);
    reg_check(srdl_pkg::ADDR_LAT, 32'h205);
    reg_check(srdl_pkg::ADDR_OFS, 32'h0);
    reg_check(srdl_pkg::ADDR_STAT, 32'h0);
    reg_check(4'h9, 32'h0);
    feed_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("src_ready_full", 32'h0, src_ready);
    reg_write(srdl_pkg::ADDR_LAT, 32'h101);
    reg_write(srdl_pkg::ADDR_CFG, 32'h48);
    i_srdl_host_model.send(srdl_pkg::CMD_ROW_OPEN, 4'h1, 1'b0);
    read_scan(32, 32, lat0);
    reg_write(srdl_pkg::ADDR_OFS, 32'h2);
    read_scan(32, 32, lat);
    chk("lat_offset", lat0 + 2, lat);
    reg_write(srdl_pkg::ADDR_OFS, 32'h0);
    reg_write(srdl_pkg::ADDR_LAT, 32'h102);
    read_scan(32, 32, lat);
    chk("lat_count", lat0 + 16, lat);
    reg_write(srdl_pkg::ADDR_LAT, 32'h101);
    reg_write(srdl_pkg::ADDR_CFG, 32'h50);
    read_scan(32, 0, lat);
    reg_write(srdl_pkg::ADDR_CFG, 32'h4e);
    read_scan(32, 32, lat);
    reg_write(srdl_pkg::ADDR_CFG, 32'h4d);
    read_scan(16, 4, lat);
    reg_write(srdl_pkg::ADDR_CFG, 32'h48);
    i_srdl_host_model.send(srdl_pkg::CMD_CLOSE, 4'h1, 1'b0);
    feed_on <= 1'b0;
    i_srdl_host_model.send(srdl_pkg::CMD_READ, 4'h1, 1'b0);
    repeat (600) @(posedge clk_sys);
    #1;
    chk("src_ready_empty", 32'h1, src_ready);
    reg_check(srdl_pkg::ADDR_STAT, 32'ha);
    reg_write(srdl_pkg::ADDR_STAT, 32'he);
    reg_check(srdl_pkg::ADDR_STAT, 32'h0);
    reg_write(srdl_pkg::ADDR_CFG, 32'hc0);
    #1;
    chk("flag_ok", srdl_pkg::LVL_PLUS, pins.flag_lvl);
    par_lat(lat0);
    reg_check(srdl_pkg::ADDR_STAT, 32'h4);
    reg_write(srdl_pkg::ADDR_LAT, 32'h201);
    reg_write(srdl_pkg::ADDR_OFS, 32'h300);
    par_lat(lat);
    chk("par_lat", lat0 + 19, lat);
    chk("flag_back", srdl_pkg::LVL_PLUS, pins.flag_lvl);
    report_and_stop();
  end
endmodule : test_srdl_top
`default_nettype wire
